//--- common/rjmp_pkg.sv
// Package for the region and register jump unit: field layout, encodings,
// register map and the structs carried between the unit and the core.
// Assumes a 64-bit general register file and 32-bit instruction words.
package rjmp_pkg;

  localparam int GPR_W = 64;

  // Instruction field positions
  localparam int OPC_HI   = 31;
  localparam int OPC_LO   = 26;
  localparam int SRC_HI   = 25;
  localparam int SRC_LO   = 21;
  localparam int RT_HI    = 20;
  localparam int RT_LO    = 16;
  localparam int LNK_HI   = 15;
  localparam int LNK_LO   = 11;
  localparam int HINT_HI  = 10;
  localparam int HINT_LO  = 6;
  localparam int FN_HI    = 5;
  localparam int FN_LO    = 0;
  localparam int BARR_BIT = 10;
  localparam int IDX_W    = 26;
  localparam int REGION_LO = 28;

  // Fixed encodings
  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] FN_REG_CALL = 6'h09;
  localparam logic [4:0] REG_ZERO    = 5'h00;
  localparam logic [4:0] REG_RA      = 5'h1f;
  localparam logic [63:0] LINK_OFS   = 64'h0000_0000_0000_0008;
  localparam logic [63:0] SLOT_OFS   = 64'h0000_0000_0000_0004;

  // Register byte addresses
  localparam logic [3:0] ADR_CTRL   = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_MASK   = 4'h8;
  localparam logic [3:0] ADR_TGT_LO = 4'hc;

  // Control bits
  localparam int CTL_ENABLE = 0;
  localparam int CTL_REL6   = 1;
  localparam int CTL_MULTI  = 2;
  localparam int CTL_SIXT   = 3;
  localparam int CTL_MODE   = 4;   // Read-only view of code_set_flag
  localparam logic [3:0] CTRL_RST = 4'h3;

  // Status / mask bits
  localparam int ST_RSVD   = 0;
  localparam int ST_ADRERR = 1;
  localparam int ST_BARR   = 2;
  localparam int ST_W      = 3;

  // One issued instruction
  typedef struct packed {
    logic             valid;
    logic [31:0]      instr;
    logic [GPR_W-1:0] pc;
    logic [GPR_W-1:0] src_val;
    logic             other_control_transfer_op;
  } rjmp_issue_s;

  // Program counter redirect
  typedef struct packed {
    logic             valid;
    logic [GPR_W-1:0] target;
    logic             mode;
    logic             barrier;
  } rjmp_redir_s;

endpackage : rjmp_pkg

//--- hdl/rjmp_target.sv
// Target former: region target, register target and mode bit.
// Pure combinational; used by the jump unit.
`timescale 1ns/1ps
module rjmp_target
  import rjmp_pkg::*;
(
  // Operands
  input  wire logic [GPR_W-1:0] pc,
  input  wire logic [IDX_W-1:0] index,
  input  wire logic [GPR_W-1:0] src_val,
  // Configuration
  input  wire logic             multi_set_present,
  input  wire logic             sixteen_bit_ext_present,
  // Results
  output logic      [GPR_W-1:0] region_target,
  output logic      [GPR_W-1:0] reg_target,
  output logic                  reg_mode_load,
  output logic                  reg_mode_val
);

  logic [GPR_W-1:0] slot_addr;
  logic             compressed;

  // Upper bits come from the delay slot, so a jump in a region's last
  // word lands in the next region
  assign slot_addr     = pc + SLOT_OFS;
  assign region_target = {slot_addr[GPR_W-1:REGION_LO], index, 2'b00};

  assign compressed = multi_set_present | sixteen_bit_ext_present;

  // Register target, bit 0 becomes the mode when a compressed set exists
  always_comb
  begin
    if (compressed)
    begin
      reg_target    = {src_val[GPR_W-1:1], 1'b0};
      reg_mode_load = 1'b1;
      reg_mode_val  = src_val[0];
    end
    else
    begin
      reg_target    = src_val;
      reg_mode_load = 1'b0;
      reg_mode_val  = 1'b0;
    end
  end

endmodule : rjmp_target

//--- hdl/rjmp_unit.sv
// Region and register jump unit: decodes region jump, region call and
// register call/return, runs the delay slot, checks target alignment.
// Assumes in-order single issue, one instruction per issue.valid pulse,
// and a fetch unit that reports each fetch address on the same clock.
//
// Functional notes
// - Region target low 28 bits are the 26-bit index shifted left two.
// - Target bits above 27 come from the delay-slot address.
// - The instruction after a jump runs before control moves.
// - Region call writes PC plus eight into register 31.
// - Release 6: control transfer in a delay slot raises reserved-instruction.
// - Register call links PC plus eight to its link field, jumps to source.
// - Source captured and link written in step one, PC loaded next step.
// - No compressed set: whole value to PC, mode unchanged.
// - Compressed set: bit 0 to mode flag, target bit 0 cleared.
// - No compressed set: low two bits nonzero fault at target fetch.
// - Compressed set: mode bit 0 with bit 1 set faults at fetch.
// - Hint zero is default; hint bit 10 asks for the barrier.
// - Release 6 return is register call with link zero; old code dropped.
`timescale 1ns/1ps
module rjmp_unit
  import rjmp_pkg::*;
#(
  parameter logic [5:0] REGION_JUMP_OPC = 6'h3a,  // Arbitrary, set from opcode table
  parameter logic [5:0] REGION_CALL_OPC = 6'h3b,  // Arbitrary, set from opcode table
  parameter logic [5:0] OLD_RETURN_FN   = 6'h3e   // Arbitrary, set from opcode table
)
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   irq,
  // Issue stream
  input  wire rjmp_issue_s       issue,
  // Link write-back
  output logic                   link_we,
  output logic      [4:0]        link_idx,
  output logic      [GPR_W-1:0]  link_data,
  // Redirect and exceptions
  output rjmp_redir_s            redirect,
  output logic                   code_set_flag,
  output logic                   rsvd_exc,
  // Fetch check
  input  wire logic              fetch_valid,
  input  wire logic [GPR_W-1:0]  fetch_addr,
  output logic                   adr_err
);

  // Decoded classes of the issued word
  typedef enum logic [1:0] {
    RJMP_NONE   = 2'b00,
    RJMP_REGION = 2'b01,
    RJMP_REG    = 2'b10
  } rjmp_kind_e;

  // Pending-jump state between step I and step I+1
  typedef enum logic [0:0] {
    RJMP_IDLE = 1'b0,
    RJMP_SLOT = 1'b1
  } rjmp_state_e;

  logic [3:0]       ctrl_q;
  logic [ST_W-1:0]  status_q;
  logic [ST_W-1:0]  status_d;
  logic [ST_W-1:0]  mask_q;
  logic             ack_q;
  logic [31:0]      rdata_q;
  logic             wr_take;
  rjmp_state_e      state_q;
  logic [GPR_W-1:0] tgt_q;
  logic             mode_ld_q;
  logic             mode_val_q;
  logic             barr_q;
  logic             mode_q;
  logic             chk_q;
  logic [GPR_W-1:0] chk_tgt_q;
  logic             chk_mode_q;
  logic             chk_comp_q;
  logic [GPR_W-1:0] last_tgt_q;
  rjmp_kind_e       kind;
  logic             is_call;
  logic [4:0]       dest;
  logic [GPR_W-1:0] region_tgt;
  logic [GPR_W-1:0] reg_tgt;
  logic             reg_mode_ld;
  logic             reg_mode_val;
  logic             slot_xfer;
  logic             ev_rsvd;
  logic             ev_adr;
  logic             ev_barr;
  logic             enable;
  logic             rel6;

  assign enable = ctrl_q[CTL_ENABLE];
  assign rel6   = ctrl_q[CTL_REL6];

  // Classify one instruction word; used for the jump and the slot check
  function automatic rjmp_kind_e decode_kind(input logic [31:0] w, input logic r6);
    logic [5:0] op;
    logic [5:0] fn;
    op = w[OPC_HI:OPC_LO];
    fn = w[FN_HI:FN_LO];
    if (op == REGION_JUMP_OPC || op == REGION_CALL_OPC)
      decode_kind = RJMP_REGION;
    else if (op == OPC_SPECIAL && fn == FN_REG_CALL && w[RT_HI:RT_LO] == REG_ZERO)
      decode_kind = RJMP_REG;
    else if (op == OPC_SPECIAL && fn == OLD_RETURN_FN && !r6)
      decode_kind = RJMP_REG;   // Old return encoding gone in release 6
    else
      decode_kind = RJMP_NONE;
  endfunction : decode_kind

  // Misfetch check of a register target at fetch time
  function automatic logic misaligned(input logic [GPR_W-1:0] a, input logic m,
                                      input logic comp);
    if (comp)
      misaligned = !m && a[1];
    else
      misaligned = a[1:0] != 2'b00;
  endfunction : misaligned

  assign kind = decode_kind(issue.instr, rel6);

  // Link destination: register 31 for region call, link field for register call
  always_comb
  begin
    is_call = 1'b0;
    dest    = REG_ZERO;
    if (kind == RJMP_REGION && issue.instr[OPC_HI:OPC_LO] == REGION_CALL_OPC)
    begin
      is_call = 1'b1;
      dest    = REG_RA;
    end
    else if (kind == RJMP_REG && issue.instr[FN_HI:FN_LO] == FN_REG_CALL
             && issue.instr[LNK_HI:LNK_LO] != REG_ZERO)
    begin
      is_call = 1'b1;
      dest    = issue.instr[LNK_HI:LNK_LO];
    end
  end

  rjmp_target u_target (
    .pc                      (issue.pc),
    .index                   (issue.instr[IDX_W-1:0]),
    .src_val                 (issue.src_val),
    .multi_set_present       (ctrl_q[CTL_MULTI]),
    .sixteen_bit_ext_present (ctrl_q[CTL_SIXT]),
    .region_target           (region_tgt),
    .reg_target              (reg_tgt),
    .reg_mode_load           (reg_mode_ld),
    .reg_mode_val            (reg_mode_val)
  );

  // Any control transfer arriving while a jump waits for its slot
  assign slot_xfer = issue.valid && state_q == RJMP_SLOT
                     && (kind != RJMP_NONE || issue.other_control_transfer_op);
  assign ev_rsvd   = slot_xfer && rel6;

  // Jump sequencing: step I captures, the slot instruction is step I+1
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q    <= RJMP_IDLE;
      tgt_q      <= '0;
      mode_ld_q  <= 1'b0;
      mode_val_q <= 1'b0;
      barr_q     <= 1'b0;
    end
    else if (issue.valid && enable)
    begin
      unique case (state_q)
        RJMP_IDLE:
          if (kind != RJMP_NONE)
          begin
            state_q    <= RJMP_SLOT;
            tgt_q      <= (kind == RJMP_REGION) ? region_tgt : reg_tgt;
            mode_ld_q  <= (kind == RJMP_REG) && reg_mode_ld;
            mode_val_q <= reg_mode_val;
            // Only register jumps carry a hint; zero means plain handling
            barr_q     <= (kind == RJMP_REG) && issue.instr[BARR_BIT];
          end
        RJMP_SLOT:
          state_q <= RJMP_IDLE;   // Slot issued; a slot jump is not chained
      endcase
    end
  end

  // Link write-back in the jump's own step
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      link_we   <= 1'b0;
      link_idx  <= REG_ZERO;
      link_data <= '0;
    end
    else
    begin
      link_we <= issue.valid && enable && state_q == RJMP_IDLE && is_call;
      if (issue.valid && state_q == RJMP_IDLE && is_call)
      begin
        link_idx  <= dest;
        link_data <= issue.pc + LINK_OFS;
      end
    end
  end

  // Redirect once the slot instruction has issued, unless it trapped
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      redirect <= '0;
      mode_q   <= 1'b0;
      rsvd_exc <= 1'b0;
    end
    else
    begin
      redirect.valid <= 1'b0;
      rsvd_exc       <= ev_rsvd && enable;
      if (issue.valid && enable && state_q == RJMP_SLOT && !ev_rsvd)
      begin
        redirect.valid   <= 1'b1;
        redirect.target  <= tgt_q;
        redirect.barrier <= barr_q;
        redirect.mode    <= mode_ld_q ? mode_val_q : mode_q;
        if (mode_ld_q)
          mode_q <= mode_val_q;
      end
    end
  end

  assign code_set_flag = mode_q;

  // Alignment is judged when the target is fetched, not at the jump
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      chk_q      <= 1'b0;
      chk_tgt_q  <= '0;
      chk_mode_q <= 1'b0;
      chk_comp_q <= 1'b0;
      adr_err    <= 1'b0;
      last_tgt_q <= '0;
    end
    else
    begin
      adr_err <= 1'b0;
      if (redirect.valid)
      begin
        chk_q      <= 1'b1;
        chk_tgt_q  <= redirect.target;
        chk_mode_q <= redirect.mode;
        chk_comp_q <= ctrl_q[CTL_MULTI] | ctrl_q[CTL_SIXT];
        last_tgt_q <= redirect.target;
      end
      else if (chk_q && fetch_valid && fetch_addr == chk_tgt_q)
      begin
        chk_q   <= 1'b0;
        adr_err <= misaligned(chk_tgt_q, chk_mode_q, chk_comp_q);
      end
    end
  end

  assign ev_adr  = adr_err;
  assign ev_barr = redirect.valid && redirect.barrier;

  // Bus answer: one wait cycle for every access, then a single ack
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read || avs_write) && !ack_q;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_take         = avs_write && ack_q;

  // Read mux, registered in the wait cycle; unmapped reads return zero
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && !ack_q)
    begin
      unique case (avs_address)
        ADR_CTRL:   rdata_q <= {27'h0000000, mode_q, ctrl_q};
        ADR_STATUS: rdata_q <= {29'h00000000, status_q};
        ADR_MASK:   rdata_q <= {29'h00000000, mask_q};
        ADR_TGT_LO: rdata_q <= last_tgt_q[31:0];
        default:    rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;

  // Control and mask registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RST;
      mask_q <= '0;
    end
    else if (wr_take)
    begin
      if (avs_address == ADR_CTRL)
        ctrl_q <= avs_writedata[3:0];
      if (avs_address == ADR_MASK)
        mask_q <= avs_writedata[ST_W-1:0];
    end
  end

  // Sticky events; a new event beats a write-one clear in the same cycle
  always_comb
  begin
    status_d = status_q;
    if (wr_take && avs_address == ADR_STATUS)
      status_d = status_q & ~avs_writedata[ST_W-1:0];
    status_d[ST_RSVD]   = status_d[ST_RSVD]   | rsvd_exc;
    status_d[ST_ADRERR] = status_d[ST_ADRERR] | ev_adr;
    status_d[ST_BARR]   = status_d[ST_BARR]   | ev_barr;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      status_q <= '0;
    else
      status_q <= status_d;
  end

  // Level interrupt while any unmasked event is pending
  assign irq = |(status_q & mask_q);

endmodule : rjmp_unit

//--- tb/rjmp_unit_props.sv
// Checker for the jump unit; watches only the top ports.
// Assumes control is changed only through the register bus.
`timescale 1ns/1ps
module rjmp_props
  import rjmp_pkg::*;
#(
  parameter logic [5:0] REGION_JUMP_OPC = 6'h3a,
  parameter logic [5:0] REGION_CALL_OPC = 6'h3b,
  parameter logic [5:0] OLD_RETURN_FN   = 6'h3e
)
(
  // Clock, reset and bus
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic [3:0]       avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_writedata,
  input wire logic             avs_waitrequest,
  // Core side
  input wire rjmp_issue_s      issue,
  input wire logic             link_we,
  input wire logic [4:0]       link_idx,
  input wire logic [GPR_W-1:0] link_data,
  input wire rjmp_redir_s      redirect,
  input wire logic             rsvd_exc
);
  logic [3:0]  ctl_q;
  logic        pend_q;
  logic [31:0] jin_q;
  logic [63:0] jsrc_q;
  logic [5:0]  opc;
  logic        rj, jmp, go, slot, rjp, cmp, xfer;

  // Decode seen from outside; old return only before release 6
  assign opc  = issue.instr[31:26];
  assign rj   = opc == OPC_SPECIAL && (issue.instr[5:0] == FN_REG_CALL
              || (!ctl_q[1] && issue.instr[5:0] == OLD_RETURN_FN));
  assign jmp  = issue.valid && ctl_q[0]
              && (rj || opc == REGION_JUMP_OPC || opc == REGION_CALL_OPC);
  assign go   = jmp && !pend_q;
  assign slot = pend_q && issue.valid && ctl_q[0];
  assign xfer = ctl_q[1] && (issue.other_control_transfer_op || jmp);
  assign rjp  = jin_q[31:26] == OPC_SPECIAL;
  assign cmp  = ctl_q[2] | ctl_q[3];

  // Mirror of control and of the jump waiting for its slot
  always_ff @(posedge clock)
    if (!rst_n)
    begin
      ctl_q  <= CTRL_RST;
      pend_q <= 1'b0;
    end
    else
    begin
      if (avs_write && !avs_waitrequest && avs_address == ADR_CTRL)
        ctl_q <= avs_writedata[3:0];
      if (issue.valid && ctl_q[0])
        pend_q <= go;
      if (go)
      begin
        jin_q  <= issue.instr;
        jsrc_q <= issue.src_val;
      end
    end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_bus_wait;
    $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("wait cycle wrong");
  property p_call_link;
    go && opc == REGION_CALL_OPC |=> link_we && link_idx == REG_RA
      && link_data == $past(issue.pc) + LINK_OFS;
  endproperty
  a_call_link: assert property (p_call_link) else $error("call link wrong");
  property p_reg_link;
    go && rj && issue.instr[5:0] == FN_REG_CALL && issue.instr[15:11] != REG_ZERO |=> link_we
      && link_idx == $past(issue.instr[15:11]) && link_data == $past(issue.pc) + LINK_OFS;
  endproperty
  a_reg_link: assert property (p_reg_link) else $error("reg link wrong");
  property p_no_link;
    go && (opc == REGION_JUMP_OPC || (rj && issue.instr[15:11] == REG_ZERO)) |=> !link_we;
  endproperty
  a_no_link: assert property (p_no_link) else $error("stray link");
  property p_hold;
    pend_q |-> !redirect.valid && !rsvd_exc;
  endproperty
  a_hold: assert property (p_hold) else $error("redirect before slot");
  property p_slot;
    slot && !xfer |=> redirect.valid && !rsvd_exc;
  endproperty
  a_slot: assert property (p_slot) else $error("no redirect after slot");
  property p_rsvd;
    slot && xfer |=> rsvd_exc && !redirect.valid;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("slot transfer not refused");
  property p_region;
    redirect.valid && !rjp |-> redirect.target == {$past(issue.pc[63:28]), jin_q[25:0], 2'b00};
  endproperty
  a_region: assert property (p_region) else $error("region target wrong");
  property p_regtgt;
    redirect.valid && rjp |-> redirect.target == (cmp ? {jsrc_q[63:1], 1'b0} : jsrc_q)
      && redirect.barrier == jin_q[BARR_BIT];
  endproperty
  a_regtgt: assert property (p_regtgt) else $error("reg target wrong");
  property p_mode;
    redirect.valid && rjp && cmp |-> redirect.mode == jsrc_q[0];
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");

  c_call: cover property (go && opc == REGION_CALL_OPC);
  c_rsvd: cover property (rsvd_exc);
  c_barr: cover property (redirect.valid && redirect.barrier);
endmodule : rjmp_props

bind rjmp_unit rjmp_props #(
  .REGION_JUMP_OPC (REGION_JUMP_OPC),
  .REGION_CALL_OPC (REGION_CALL_OPC),
  .OLD_RETURN_FN   (OLD_RETURN_FN)
) u_props (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .issue(issue), .link_we(link_we),
  .link_idx(link_idx), .link_data(link_data), .redirect(redirect), .rsvd_exc(rsvd_exc));

//--- tb/testbench.sv
// Self-checking bench for the jump unit: bus, issue, fetch and irq.
// Drives every port itself at rising edges; no partner model.
`timescale 1ns/1ps
module testbench
  import rjmp_pkg::*;
;
  localparam logic [5:0] RJ = 6'h3a, RC = 6'h3b, OLDF = 6'h3e;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, irq, link_we, code_set_flag, rsvd_exc, adr_err;
  logic [4:0]  link_idx;
  logic [63:0] link_data;
  rjmp_issue_s iss = '0;
  rjmp_redir_s redir;
  logic        fetch_valid = 1'b0;
  logic [63:0] fetch_addr = 64'h0;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;

  rjmp_unit #(.REGION_JUMP_OPC(RJ), .REGION_CALL_OPC(RC), .OLD_RETURN_FN(OLDF)) dut (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .issue(iss), .link_we(link_we),
    .link_idx(link_idx), .link_data(link_data), .redirect(redir),
    .code_set_flag(code_set_flag), .rsvd_exc(rsvd_exc), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .adr_err(adr_err));

  // 40 MHz clock and a hang limit well above the run length
  always #12.5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      results();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One bus cycle; request held until waitrequest is sampled low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clock);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    do
      @(posedge clock);
    while (avs_waitrequest);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    #1;
  endtask : bus

  // One-cycle issue pulse; returns just after the taking edge settles
  task automatic put(input logic [31:0] ins, input logic [63:0] pc,
                     input logic [63:0] src, input logic xfer);
    @(posedge clock);
    iss <= {1'b1, ins, pc, src, xfer};
    @(posedge clock);
    iss.valid <= 1'b0;
    #1;
  endtask : put

  task automatic fetch(input logic [63:0] a, input logic exp);
    @(posedge clock);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    @(posedge clock);
    fetch_valid <= 1'b0;
    #1;
    chk(adr_err, exp);
  endtask : fetch

  function automatic logic [31:0] rcall(input logic [4:0] lnk, input logic [4:0] hint,
                                        input logic [5:0] fn);
    return {OPC_SPECIAL, 5'h03, 5'h00, lnk, hint, fn};
  endfunction : rcall

  task automatic t_regs;
    bus(0, ADR_CTRL, 0);
    chk(rd, 32'h3);
    bus(0, 4'h2, 0);
    chk(rd, 32'h0);
  endtask : t_regs

  // Call in the last word of a region: slot sits in the next region
  task automatic t_region;
    put({RC, 26'h155_5553}, 64'h0000_0002_0fff_fffc, 0, 0);
    chk({link_we, link_idx}, {1'b1, REG_RA});
    chk(link_data, 64'h0000_0002_1000_0004);
    chk(redir.valid, 0);
    put(32'h0, 64'h0000_0002_1000_0000, 0, 0);
    chk(redir.valid, 1);
    chk(redir.target, 64'h0000_0002_1555_554c);
    fetch(64'h0000_0002_1555_554c, 0);
    put({RJ, 26'h000_0001}, 64'h40, 0, 0);
    chk(link_we, 0);
    put(32'h0, 64'h44, 0, 0);
    chk(redir.target, 64'h4);
  endtask : t_region

  // Plain set: whole value, misaligned fetch, status, mask and irq
  task automatic t_reg;
    put(rcall(5'h07, 5'h00, FN_REG_CALL), 64'h100, 64'h2002, 0);
    chk({link_we, link_idx}, {1'b1, 5'h07});
    chk(link_data, 64'h108);
    put(32'h0, 64'h104, 0, 0);
    chk(redir.target, 64'h2002);
    chk({redir.barrier, code_set_flag}, 0);
    fetch(64'h2002, 1);
    bus(0, ADR_TGT_LO, 0);
    chk(rd, 32'h2002);
    bus(0, ADR_STATUS, 0);
    chk(rd[ST_ADRERR], 1);
    chk(irq, 0);
    bus(1, ADR_MASK, 32'h2);
    chk(irq, 1);
    bus(1, ADR_STATUS, 32'h7);
    chk(irq, 0);
  endtask : t_reg

  // Compressed sets: return with barrier, mode taken from bit 0
  task automatic t_comp;
    bus(1, ADR_CTRL, 32'h7);
    put(rcall(5'h00, 5'h10, FN_REG_CALL), 64'h200, 64'h3001, 0);
    chk(link_we, 0);
    put(32'h0, 64'h204, 0, 0);
    chk(redir.target, 64'h3000);
    chk({redir.mode, redir.barrier}, 2'b11);
    fetch(64'h3000, 0);
    chk(code_set_flag, 1);
    bus(1, ADR_CTRL, 32'hb);
    put(rcall(5'h1f, 5'h00, FN_REG_CALL), 64'h300, 64'h4002, 0);
    put(32'h0, 64'h304, 0, 0);
    chk(redir.target, 64'h4002);
    chk(redir.mode, 1'b0);
    fetch(64'h4002, 1);
    bus(1, ADR_STATUS, 32'h7);
  endtask : t_comp

  // Transfers in the slot: refused in release 6, ignored before it
  task automatic t_slot;
    bus(1, ADR_CTRL, 32'h3);
    put({RJ, 26'h10}, 64'h400, 0, 0);
    put(32'h0, 64'h404, 0, 1);
    chk({rsvd_exc, redir.valid}, 2'b10);
    put({RJ, 26'h10}, 64'h500, 0, 0);
    put(rcall(5'h02, 5'h00, FN_REG_CALL), 64'h504, 64'h8, 0);
    chk({rsvd_exc, redir.valid}, 2'b10);
    bus(0, ADR_STATUS, 0);
    chk(rd[ST_RSVD], 1);
    bus(1, ADR_CTRL, 32'h1);
    put({RJ, 26'h10}, 64'h600, 0, 0);
    put(32'h0, 64'h604, 0, 1);
    chk({rsvd_exc, redir.valid}, 2'b01);
  endtask : t_slot

  // Old return code: known before release 6 only; enable off ignores all
  task automatic t_old;
    put(rcall(5'h00, 5'h00, OLDF), 64'h700, 64'h6000, 0);
    put(32'h0, 64'h704, 0, 0);
    chk({redir.valid, redir.target}, {1'b1, 64'h6000});
    bus(1, ADR_CTRL, 32'h3);
    put(rcall(5'h00, 5'h00, OLDF), 64'h800, 64'h6000, 0);
    put(32'h0, 64'h804, 0, 0);
    chk(redir.valid, 0);
    bus(1, ADR_CTRL, 32'h2);
    put({RJ, 26'h10}, 64'h900, 0, 0);
    put(32'h0, 64'h904, 0, 0);
    chk({link_we, redir.valid}, 0);
    bus(1, ADR_CTRL, 32'h3);
  endtask : t_old

  task automatic results;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // Reset for six cycles, then the scenarios in turn
  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_region();
    t_reg();
    t_comp();
    t_slot();
    t_old();
    results();
  end
endmodule : testbench
